/* File: hw/can_mode_defines.svh */
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH
`define OFF_CTRL1 8'h00
`define OFF_CFG2 8'h04
`define OFF_BAUD 8'h08
`define OFF_STAT 8'h0c
`define OFF_ERRC 8'h10
`define OFF_FILT 8'h14
`define OFF_PRIO 8'h18
`define REQ_LSB 8
`define OPM_LSB 5
`define ABORT_ALL_BIT 12
`define WAKE_LP_BIT 14
`define MODE_NORMAL 3'h0
`define MODE_DISABLE 3'h1
`define MODE_LOOPBACK 3'h2
`define MODE_LISTEN_ONLY 3'h3
`define MODE_CONFIG 3'h4
`define MODE_LISTEN_ALL 3'h7
`define MODE_RST 3'h4
`define IDLE_BITS 4'hb
`define MAX_OVERLOAD 2'h2
`define STD_ID_BITS 5'h0b
`define EXT_ID_BITS 5'h12
`define MAX_DATA_BYTES 4'h8
`define MIN_BIT_TIME_NS 1000
`define CLK_PERIOD_NS 5
`define MIN_BIT_CLKS ((`MIN_BIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: hw/can_mode_pkg.sv */
package can_mode_pkg;
  typedef logic [2:0] mode_code_t;
  typedef struct packed {
    logic tx_en;
    logic rx_en;
    logic err_sig_en;
    logic err_cnt_en;
    logic accept_all;
    logic loopback;
  } eng_ctl_t;
  typedef struct packed {
    logic tx_err;
    logic rx_err;
  } err_evt_t;
endpackage

/* File: hw/can_mode_ctrl.sv */
`include "can_mode_defines.svh"
module can_mode_ctrl
  import can_mode_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NUM_TXB = 8,
  parameter int NUM_RXB = 32,
  parameter int NUM_FILT = 16,
  parameter int NUM_MASK = 3,
  parameter int WAKE_FILT_CLKS = 40
)
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register bus.
  input wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  output logic [1:0] o_s_axi_bresp,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  input wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  // Bus pins.
  input wire logic i_bus_receive_pin,
  output logic o_bus_transmit_pin,
  output logic o_bus_transmit_pin_oe,
  output logic o_bus_receive_pin_owned,
  // Protocol engine.
  input wire logic i_eng_tx,
  output logic o_eng_rx,
  output eng_ctl_t o_eng_ctl,
  output logic o_bit_tick,
  input wire err_evt_t i_err_evt,
  input wire logic i_tx_busy,
  input wire logic i_tx_done,
  output logic o_tx_go,
  output logic [$clog2(NUM_TXB)-1:0] o_tx_buf,
  input wire logic i_remote_match,
  input wire logic [$clog2(NUM_TXB)-1:0] i_remote_buf,
  input wire logic i_ovl_need,
  input wire logic i_frame_start,
  output logic o_ovl_send,
  input wire logic i_err_detect,
  output logic o_err_frame_send,
  input wire logic i_rx_ide,
  output logic [4:0] o_id_bits,
  input wire logic [3:0] i_rx_dlc,
  output logic [3:0] o_rx_len,
  input wire logic i_rx_checked,
  input wire logic [NUM_FILT-1:0] i_filt_hit,
  output logic o_rx_store,
  output logic [$clog2(NUM_RXB)-1:0] o_rx_buf
);
  localparam int TXB_W = $clog2(NUM_TXB);
  localparam int RXB_W = $clog2(NUM_RXB);
  localparam int LP_W = $clog2(WAKE_FILT_CLKS+1);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic mode_legal(input mode_code_t m);
    return (m != 3'h5) && (m != 3'h6);
  endfunction

  // Highest software priority wins; on a tie the higher buffer index wins.
  function automatic logic [TXB_W-1:0] pick(input logic [NUM_TXB-1:0] req,
                                            input logic [2*NUM_TXB-1:0] pri);
    logic [TXB_W-1:0] best;
    logic [2:0] best_p;
    best = '0;
    best_p = 3'h0;
    for (int i = 0; i < NUM_TXB; i++)
    begin
      if (req[i] && ({1'b1, pri[2*i +: 2]} >= best_p))
      begin
        best = TXB_W'(i);
        best_p = {1'b1, pri[2*i +: 2]};
      end
    end
    return best;
  endfunction

  logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r;
  mode_code_t req_r, mode_r;
  logic wake_lp_en_r, wake_flag_r, abort_all;
  logic [15:0] baud_r, bit_cnt_r;
  logic [NUM_FILT-1:0] filt_en_r;
  logic [2*NUM_TXB-1:0] prio_r;
  logic [NUM_TXB-1:0] tx_request_flag_r, tx_aborted_flag_r;
  logic [TXB_W-1:0] cur_buf_r;
  logic [7:0] tx_err_cnt_r, rx_err_cnt_r;
  logic rx_meta_r, rx_sync_r, rx_lp_r, wake_prev_r;
  logic [LP_W-1:0] lp_cnt_r;
  logic [3:0] rec_cnt_r;
  logic [1:0] ovl_cnt_r;
  logic wr_fire, wr_prot, wr_ok, tick, idle, mode_chg, wake_rx;
  logic filt_active, dis_wr, abort_now;
  logic [31:0] rd_mux;
  logic [31:0] cfg2_nxt, baud_nxt, filt_nxt, prio_nxt;

  // Register bus slave: address and data are caught in either order.
  assign o_s_axi_awready = !aw_held_r && !bvalid_r;
  assign o_s_axi_wready = !w_held_r && !bvalid_r;
  assign o_s_axi_arready = !rvalid_r;
  assign o_s_axi_bvalid = bvalid_r;
  assign o_s_axi_bresp = bresp_r;
  assign o_s_axi_rvalid = rvalid_r;
  assign o_s_axi_rdata = rdata_r;
  assign o_s_axi_rresp = `RESP_OKAY;
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
  assign wr_prot = (awaddr_r == `OFF_CFG2) || (awaddr_r == `OFF_BAUD)
                || (awaddr_r == `OFF_FILT) || (awaddr_r == `OFF_PRIO);
  // A locked register is left alone and the write answers with an error.
  assign wr_ok = wr_fire && !(wr_prot && (mode_r != `MODE_CONFIG));

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
    end
    else
    begin
      if (i_s_axi_awvalid && o_s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= i_s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held_r <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= i_s_axi_wdata;
        wstrb_r <= i_s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      if (awaddr_r > `OFF_PRIO || awaddr_r[1:0] != 2'h0)
      begin
        bresp_r <= `RESP_SLVERR;
      end
    end
    else if (i_s_axi_bready)
    begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb
  begin
    rd_mux = 32'h0;
    case (i_s_axi_araddr)
      `OFF_CTRL1: rd_mux = {21'h0, req_r, mode_r, 5'h0};
      `OFF_CFG2: rd_mux = {17'h0, wake_lp_en_r, 14'h0};
      `OFF_BAUD: rd_mux = {16'h0, baud_r};
      `OFF_STAT: rd_mux = {7'h0, idle, 7'h0, wake_flag_r, 8'(tx_aborted_flag_r), 8'(tx_request_flag_r)};
      `OFF_ERRC: rd_mux = {16'h0, tx_err_cnt_r, rx_err_cnt_r};
      `OFF_FILT: rd_mux = 32'(filt_en_r);
      `OFF_PRIO: rd_mux = 32'(prio_r);
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
    end
    else if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
    end
    else if (i_s_axi_rready)
    begin
      rvalid_r <= 1'b0;
    end
  end

  // Byte strobes merge into the current contents, so a partial write keeps the rest.
  assign cfg2_nxt = merge({17'h0, wake_lp_en_r, 14'h0}, wdata_r, wstrb_r);
  assign baud_nxt = merge({16'h0, baud_r}, wdata_r, wstrb_r);
  assign filt_nxt = merge(32'(filt_en_r), wdata_r, wstrb_r);
  assign prio_nxt = merge(32'(prio_r), wdata_r, wstrb_r);

  // Software-written configuration that steers the block.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wake_lp_en_r <= 1'b0;
      baud_r <= 16'(`MIN_BIT_CLKS);
      filt_en_r <= '0;
      prio_r <= '0;
    end
    else if (wr_ok)
    begin
      if (awaddr_r == `OFF_CFG2)
      begin
        wake_lp_en_r <= cfg2_nxt[`WAKE_LP_BIT];
      end
      if (awaddr_r == `OFF_BAUD)
      begin
        // Bit times shorter than one microsecond are raised to it.
        baud_r <= (baud_nxt[15:0] < 16'(`MIN_BIT_CLKS)) ? 16'(`MIN_BIT_CLKS)
                : baud_nxt[15:0];
      end
      if (awaddr_r == `OFF_FILT)
      begin
        filt_en_r <= filt_nxt[NUM_FILT-1:0];
      end
      if (awaddr_r == `OFF_PRIO)
      begin
        prio_r <= prio_nxt[2*NUM_TXB-1:0];
      end
    end
  end

  // Bit-rate enable.
  assign tick = (bit_cnt_r == 16'h0);
  assign o_bit_tick = tick;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      bit_cnt_r <= 16'h0;
    end
    else
    begin
      bit_cnt_r <= tick ? baud_r - 16'h1 : bit_cnt_r - 16'h1;
    end
  end

  // Receive pin synchroniser and sleep low-pass filter.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end
    else
    begin
      rx_meta_r <= i_bus_receive_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  // A short glitch on a sleeping bus must not count as wake-up activity.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      lp_cnt_r <= '0;
      rx_lp_r <= 1'b1;
    end
    else if (rx_sync_r)
    begin
      lp_cnt_r <= '0;
      rx_lp_r <= 1'b1;
    end
    else if (lp_cnt_r == LP_W'(WAKE_FILT_CLKS))
    begin
      rx_lp_r <= 1'b0;
    end
    else
    begin
      lp_cnt_r <= lp_cnt_r + 1'b1;
    end
  end

  assign filt_active = wake_lp_en_r && (mode_r == `MODE_DISABLE);
  assign wake_rx = filt_active ? rx_lp_r : rx_sync_r;
  assign o_eng_rx = o_eng_ctl.loopback ? i_eng_tx : rx_sync_r;

  // Idle detector; a mode change restarts the count so that a new mode
  // also waits for a fresh idle stretch before its first transmission.
  assign idle = (rec_cnt_r == `IDLE_BITS);
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      rec_cnt_r <= 4'h0;
    end
    else if (mode_chg)
    begin
      rec_cnt_r <= 4'h0;
    end
    else if (tick)
    begin
      if (!o_eng_rx)
      begin
        rec_cnt_r <= 4'h0;
      end
      else if (!idle)
      begin
        rec_cnt_r <= rec_cnt_r + 4'h1;
      end
    end
  end

  // Mode request and acknowledge.
  assign mode_chg = mode_legal(req_r) && (req_r != mode_r) && idle
                 && !((req_r == `MODE_CONFIG) && i_tx_busy);
  assign dis_wr = wr_ok && (awaddr_r == `OFF_CTRL1) && wstrb_r[1]
               && (wdata_r[`REQ_LSB +: 3] == `MODE_DISABLE);
  assign abort_all = wr_ok && (awaddr_r == `OFF_CTRL1) && wstrb_r[1]
                  && wdata_r[`ABORT_ALL_BIT];
  assign abort_now = (dis_wr || abort_all) && !i_tx_busy;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      req_r <= `MODE_RST;
    end
    else if (wr_fire && (awaddr_r == `OFF_CTRL1) && wstrb_r[1])
    begin
      req_r <= wdata_r[`REQ_LSB +: 3];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mode_r <= `MODE_RST;
    end
    else if (mode_chg)
    begin
      mode_r <= req_r;
    end
  end

  // Per-mode engine and pin control.
  always_comb
  begin
    o_eng_ctl = '0;
    o_bus_transmit_pin_oe = 1'b0;
    o_bus_receive_pin_owned = 1'b0;
    case (mode_r)
      `MODE_NORMAL:
      begin
        o_eng_ctl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        o_bus_transmit_pin_oe = 1'b1;
        o_bus_receive_pin_owned = 1'b1;
      end
      `MODE_LISTEN_ONLY:
      begin
        o_eng_ctl = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        o_bus_receive_pin_owned = 1'b1;
      end
      `MODE_LISTEN_ALL:
      begin
        o_eng_ctl = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
        o_bus_receive_pin_owned = 1'b1;
      end
      `MODE_LOOPBACK:
      begin
        o_eng_ctl = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
      end
      default:
      begin
        o_eng_ctl = '0;
      end
    endcase
  end
  assign o_bus_transmit_pin = o_bus_transmit_pin_oe ? i_eng_tx : 1'b1;

  // Wake-up flag, cleared by writing one; a new event wins over the clear.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wake_flag_r <= 1'b0;
      wake_prev_r <= 1'b1;
    end
    else
    begin
      wake_prev_r <= wake_rx;
      if ((mode_r == `MODE_DISABLE) && wake_prev_r && !wake_rx)
      begin
        wake_flag_r <= 1'b1;
      end
      else if (wr_ok && (awaddr_r == `OFF_STAT) && wstrb_r[2] && wdata_r[16])
      begin
        wake_flag_r <= 1'b0;
      end
    end
  end

  // Error counters: cleared in configuration, frozen when not counting.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tx_err_cnt_r <= 8'h0;
      rx_err_cnt_r <= 8'h0;
    end
    else if (mode_r == `MODE_CONFIG)
    begin
      tx_err_cnt_r <= 8'h0;
      rx_err_cnt_r <= 8'h0;
    end
    else if (o_eng_ctl.err_cnt_en)
    begin
      if (i_err_evt.tx_err && tx_err_cnt_r != 8'hff)
      begin
        tx_err_cnt_r <= tx_err_cnt_r + 8'h1;
      end
      if (i_err_evt.rx_err && rx_err_cnt_r != 8'hff)
      begin
        rx_err_cnt_r <= rx_err_cnt_r + 8'h1;
      end
    end
  end

  // Transmit requests. The engine must raise busy the cycle after go.
  assign o_tx_buf = pick(tx_request_flag_r, prio_r);
  assign o_tx_go = (|tx_request_flag_r) && o_eng_ctl.tx_en && idle && !i_tx_busy;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tx_request_flag_r <= '0;
      tx_aborted_flag_r <= '0;
      cur_buf_r <= '0;
    end
    else
    begin
      if (o_tx_go)
      begin
        cur_buf_r <= o_tx_buf;
      end
      if (abort_now)
      begin
        tx_aborted_flag_r <= tx_aborted_flag_r | tx_request_flag_r;
        tx_request_flag_r <= '0;
      end
      else
      begin
        if (wr_ok && (awaddr_r == `OFF_STAT) && wstrb_r[1])
        begin
          tx_aborted_flag_r <= tx_aborted_flag_r & ~wdata_r[8 +: NUM_TXB];
        end
        if (wr_ok && (awaddr_r == `OFF_STAT) && wstrb_r[0])
        begin
          tx_request_flag_r <= tx_request_flag_r | wdata_r[NUM_TXB-1:0];
        end
        if (i_tx_done)
        begin
          tx_request_flag_r[cur_buf_r] <= 1'b0;
        end
        if (i_remote_match)
        begin
          tx_request_flag_r[i_remote_buf] <= 1'b1;
        end
      end
    end
  end

  // Overload and error frame requests to the engine.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ovl_cnt_r <= 2'h0;
      o_ovl_send <= 1'b0;
      o_err_frame_send <= 1'b0;
    end
    else
    begin
      o_ovl_send <= 1'b0;
      o_err_frame_send <= i_err_detect && o_eng_ctl.err_sig_en;
      if (i_frame_start)
      begin
        ovl_cnt_r <= 2'h0;
      end
      else if (i_ovl_need && o_eng_ctl.err_sig_en && ovl_cnt_r < `MAX_OVERLOAD)
      begin
        ovl_cnt_r <= ovl_cnt_r + 2'h1;
        o_ovl_send <= 1'b1;
      end
    end
  end

  // Frame format helpers and receive storage decision.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_id_bits <= `STD_ID_BITS;
      o_rx_len <= 4'h0;
      o_rx_store <= 1'b0;
      o_rx_buf <= '0;
    end
    else
    begin
      o_id_bits <= i_rx_ide ? `STD_ID_BITS + `EXT_ID_BITS : `STD_ID_BITS;
      o_rx_len <= (i_rx_dlc > `MAX_DATA_BYTES) ? `MAX_DATA_BYTES : i_rx_dlc;
      o_rx_store <= i_rx_checked && o_eng_ctl.rx_en
                 && (o_eng_ctl.accept_all || |(i_filt_hit & filt_en_r));
      if (i_rx_checked && o_eng_ctl.rx_en)
      begin
        o_rx_buf <= o_rx_buf + 1'b1;
      end
    end
  end
endmodule // can_mode_ctrl

/* File: sim/can_mode_props.sv */
module can_mode_props
  import can_mode_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Watched ports.
  input wire logic i_eng_tx,
  input wire logic i_err_detect,
  input wire logic i_frame_start,
  input wire logic i_rx_checked,
  input wire logic o_eng_rx,
  input wire logic o_bus_transmit_pin,
  input wire logic o_bus_transmit_pin_oe,
  input wire logic o_bus_receive_pin_owned,
  input wire eng_ctl_t o_eng_ctl,
  input wire logic o_bit_tick,
  input wire logic o_err_frame_send,
  input wire logic o_ovl_send,
  input wire logic [3:0] o_rx_len
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [3:0] idle_r;
  logic [1:0] ovl_r;
  // Clearing on a dominant tick or an engine control change keeps this count no more than one below the block's own.
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || $changed(o_eng_ctl) || (o_bit_tick && !o_eng_rx))
      idle_r <= 4'h0;
    else if (o_bit_tick && idle_r != 4'hf)
      idle_r <= idle_r + 4'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || i_frame_start)
      ovl_r <= 2'h0;
    else if (o_ovl_send && ovl_r != 2'h3)
      ovl_r <= ovl_r + 2'h1;
  end
  sequence err_seen_s;
    i_err_detect && o_eng_ctl.err_sig_en;
  endsequence
  sequence frame_sent_s;
    ##1 o_err_frame_send;
  endsequence
  drive_normal_a: assert property (
    o_bus_transmit_pin_oe |-> o_eng_ctl == 6'h3c) else $error("Pin driven off normal.");
  pin_release_a: assert property (
    !o_bus_transmit_pin_oe |-> o_bus_transmit_pin) else $error("Released pin not high.");
  pin_follow_a: assert property (
    o_bus_transmit_pin_oe |-> o_bus_transmit_pin == i_eng_tx) else $error("Pin not engine.");
  loop_route_a: assert property (
    o_eng_ctl.loopback |-> o_eng_rx == i_eng_tx && !o_bus_receive_pin_owned)
    else $error("Loop not routed.");
  stay_passive_a: assert property (
    o_eng_ctl.rx_en && !o_eng_ctl.tx_en |-> !o_eng_ctl.err_sig_en && !o_eng_ctl.err_cnt_en)
    else $error("Passive mode active.");
  err_frame_a: assert property (
    err_seen_s |-> frame_sent_s) else $error("Error frame missing.");
  err_cause_a: assert property (
    o_err_frame_send |-> $past(i_err_detect)) else $error("Error frame uncaused.");
  mode_idle_a: assert property (
    $changed(o_eng_ctl) |-> idle_r >= 4'ha) else $error("Mode changed on busy bus.");
  ovl_limit_a: assert property (
    o_ovl_send |-> ovl_r < 2'h2) else $error("Third overload frame.");
  rx_len_a: assert property (
    i_rx_checked |=> o_rx_len <= 4'h8) else $error("Length above eight.");
endmodule // can_mode_props

bind can_mode_ctrl can_mode_props i_can_mode_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_eng_tx(i_eng_tx), .i_err_detect(i_err_detect),
  .i_frame_start(i_frame_start), .i_rx_checked(i_rx_checked), .o_eng_rx(o_eng_rx),
  .o_bus_transmit_pin(o_bus_transmit_pin), .o_bus_transmit_pin_oe(o_bus_transmit_pin_oe),
  .o_bus_receive_pin_owned(o_bus_receive_pin_owned), .o_eng_ctl(o_eng_ctl),
  .o_bit_tick(o_bit_tick), .o_err_frame_send(o_err_frame_send), .o_ovl_send(o_ovl_send),
  .o_rx_len(o_rx_len)
);

/* File: sim/can_bus_node.sv */
module can_bus_node (
  // Clock.
  input wire logic i_clk,
  // Bench control.
  input wire logic i_talk,
  // Bus side.
  input wire logic i_tx_pin,
  input wire logic i_tx_oe,
  output logic o_rx_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] phase_r = 11'h000;
  logic level;
  always_ff @(posedge i_clk)
  begin
    phase_r <= (phase_r == 11'h7cf) ? 11'h000 : phase_r + 11'h001;
  end
  // Six dominant bits of another node's error flag, repeated so the gaps stay short.
  assign level = !(i_talk && phase_r < 11'h4b0);
  // Dominant wins on the wire.
  assign o_rx_pin = level & (i_tx_oe ? i_tx_pin : 1'b1);
endmodule // can_bus_node

/* File: sim/can_controller_mode_control_test.sv */
`include "can_mode_defines.svh"
module can_controller_mode_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n = 1'b0, talk = 1'b0, eng_tx = 1'b1, tx_busy = 1'b0;
  logic ovl_need = 1'b0, err_detect = 1'b0, rx_ide = 1'b0, rx_checked = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [1:0] err_evt = 2'h0;
  logic [3:0] rx_dlc = 4'h0;
  logic [15:0] filt_hit = 16'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata, d, f, r, seed = 32'h00013f24;
  logic awready, wready, bvalid, arready, rvalid, bus_rx, tx_pin, tx_oe, rx_owned, eng_rx;
  logic [1:0] bresp, rresp;
  logic [5:0] eng_ctl;
  logic [1:0] wq [$];
  logic [63:0] rq [$];
  logic [63:0] note;
  logic [2:0] codes [3] = '{3'h3, 3'h7, 3'h2};
  logic [7:0] pinset [3] = '{8'h50, 8'h52, 8'h3d};
  int n_errors = 0;
  int n_tests = 0;
  int n;
  int n_ovl = 0;
  int n_efr = 0;
  logic frame_start = 1'b0, live = 1'b0, ovl_send, err_send;
  logic [4:0] id_bits;
  logic [3:0] rx_len;
  logic [8:0] xq [$];
  logic [8:0] xn;

  can_mode_ctrl #(.WAKE_FILT_CLKS(4)) i_can_mode_ctrl (
    .i_clk(clk), .i_rst_n(rst_n),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
    .i_bus_receive_pin(bus_rx), .o_bus_transmit_pin(tx_pin), .o_bus_transmit_pin_oe(tx_oe),
    .o_bus_receive_pin_owned(rx_owned), .i_eng_tx(eng_tx), .o_eng_rx(eng_rx),
    .o_eng_ctl(eng_ctl), .o_bit_tick(), .i_err_evt(err_evt), .i_tx_busy(tx_busy),
    .i_tx_done(1'b0), .o_tx_go(), .o_tx_buf(), .i_remote_match(1'b0), .i_remote_buf(3'h0),
    .i_ovl_need(ovl_need), .i_frame_start(frame_start), .o_ovl_send(ovl_send),
    .i_err_detect(err_detect), .o_err_frame_send(err_send), .i_rx_ide(rx_ide),
    .o_id_bits(id_bits), .i_rx_dlc(rx_dlc), .o_rx_len(rx_len),
    .i_rx_checked(rx_checked), .i_filt_hit(filt_hit), .o_rx_store(), .o_rx_buf()
  );
  can_bus_node i_can_bus_node (
    .i_clk(clk), .i_talk(talk), .i_tx_pin(tx_pin), .i_tx_oe(tx_oe), .o_rx_pin(bus_rx)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] pins();
    return {24'h0, tx_oe, rx_owned, eng_ctl};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic aw_t, w_t, b_t;
    wq.push_back(e);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid && bready;
      if (aw_t)
        awvalid <= 1'b0;
      if (w_t)
        wvalid <= 1'b0;
    end
    while (!b_t);
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic ar_t, r_t;
    rq.push_back({m, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid && rready;
      if (r_t)
        d = rdata;
      if (ar_t)
        arvalid <= 1'b0;
    end
    while (!r_t);
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Polls sparsely, since each change needs eleven bit times of idle bus.
  task automatic go(input logic [2:0] c);
    int k;
    k = 0;
    wr(`OFF_CTRL1, {21'h0, c, 8'h0}, `RESP_OKAY);
    do
    begin
      repeat (100) @(posedge clk);
      rd(`OFF_CTRL1, 32'h0, 32'h0);
      k++;
    end
    while (d[7:5] !== c && k < 40);
    rd(`OFF_CTRL1, 32'h7e0, {21'h0, c, c, 5'h0});
  endtask

  always @(posedge clk)
  begin
    if (bvalid && bready)
      check({30'h0, bresp}, {30'h0, wq.pop_front()});
    if (rvalid && rready)
    begin
      note = rq.pop_front();
      check({30'h0, rresp}, 32'h0);
      if (note[63:32] != 32'h0)
        check(rdata & note[63:32], note[31:0]);
    end
  end

  always @(posedge clk)
  begin
    r = xs();
    live <= rst_n;
    xq.push_back({r[0] ? 5'(`STD_ID_BITS + `EXT_ID_BITS) : `STD_ID_BITS,
                  (r[4:1] > `MAX_DATA_BYTES) ? `MAX_DATA_BYTES : r[4:1]});
    rx_ide <= r[0];
    rx_dlc <= r[4:1];
    filt_hit <= r[20:5];
    rx_checked <= r[21] & r[22];
  end

  // Registered outputs settle by the falling edge, one cycle after their inputs.
  always @(negedge clk)
  begin
    n_ovl += ovl_send;
    n_efr += err_send;
    if (xq.size() == 2)
    begin
      xn = xq.pop_front();
      if (live)
        check({23'h0, id_bits, rx_len}, {23'h0, xn});
    end
  end

  // Ten mode waits of about 2300 cycles each, with ample margin.
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(pins(), 32'h0);
    check({31'h0, tx_pin}, 32'h1);
    rd(`OFF_CTRL1, 32'h7e0, 32'h480);
    wr(`OFF_BAUD, 32'h5, `RESP_OKAY);
    rd(`OFF_BAUD, 32'hffff, 32'hc8);
    wr(`OFF_CFG2, 32'h4000, `RESP_OKAY);
    rd(`OFF_CFG2, 32'h4000, 32'h4000);
    f = xs() & 32'hffff;
    wr(`OFF_FILT, f, `RESP_OKAY);
    rd(`OFF_FILT, 32'hffff, f);
    rd(8'h1c, 32'hffffffff, 32'h0);
    wr(8'h02, 32'h1, `RESP_SLVERR);
    $display("test config done");
    talk <= 1'b1;
    wr(`OFF_CTRL1, 32'h0, `RESP_OKAY);
    repeat (3000) @(posedge clk);
    rd(`OFF_CTRL1, 32'h7e0, 32'h80);
    talk <= 1'b0;
    go(3'h0);
    check(pins(), 32'hfc);
    wr(`OFF_FILT, 32'h1, `RESP_SLVERR);
    wr(`OFF_CFG2, 32'h0, `RESP_SLVERR);
    n = int'(xs() & 32'h7) + 1;
    repeat (n)
    begin
      err_evt <= 2'h3;
      err_detect <= 1'b1;
      ovl_need <= 1'b1;
      @(posedge clk);
      err_evt <= 2'h0;
      err_detect <= 1'b0;
      ovl_need <= 1'b0;
      @(posedge clk);
    end
    frame_start <= 1'b1;
    @(posedge clk);
    frame_start <= 1'b0;
    ovl_need <= 1'b1;
    @(posedge clk);
    ovl_need <= 1'b0;
    repeat (2) @(posedge clk);
    check(32'(n_efr), 32'(n));
    check(32'(n_ovl), (n > 1) ? 32'h3 : 32'(n + 1));
    wr(`OFF_STAT, 32'h1, `RESP_OKAY);
    wr(`OFF_CTRL1, 32'h100, `RESP_OKAY);
    rd(`OFF_STAT, 32'hffff, 32'h100);
    $display("test normal done");
    go(3'h1);
    rd(`OFF_ERRC, 32'hffff, {16'h0, 8'(n), 8'(n)});
    check(pins(), 32'h0);
    talk <= 1'b1;
    repeat (1300) @(posedge clk);
    talk <= 1'b0;
    rd(`OFF_STAT, 32'h10000, 32'h10000);
    wr(`OFF_STAT, 32'h10000, `RESP_OKAY);
    rd(`OFF_STAT, 32'h10000, 32'h0);
    wr(`OFF_CTRL1, 32'h500, `RESP_OKAY);
    repeat (2600) @(posedge clk);
    rd(`OFF_CTRL1, 32'h7e0, 32'h520);
    $display("test disable done");
    for (int i = 0; i < 3; i++)
    begin
      go(codes[i]);
      check(pins(), {24'h0, pinset[i]});
    end
    eng_tx <= 1'b0;
    repeat (2) @(posedge clk);
    check({31'h0, eng_rx}, 32'h0);
    eng_tx <= 1'b1;
    $display("test passive done");
    go(3'h0);
    tx_busy <= 1'b1;
    wr(`OFF_CTRL1, 32'h400, `RESP_OKAY);
    repeat (2600) @(posedge clk);
    rd(`OFF_CTRL1, 32'h7e0, 32'h400);
    tx_busy <= 1'b0;
    go(3'h4);
    rd(`OFF_ERRC, 32'hffff, 32'h0);
    check(pins(), 32'h0);
    $display("test reconfig done");
    give_verdict();
  end
endmodule // can_controller_mode_control_test
